// [rtl/dcwd_top.sv]
// drive control word register and command decoder
// Operation
// - hold 16-bit control word, reset zero
// - shutdown 110, switch on 0111
// - 1111 gives enable operation
// - disable voltage, quick stop, fault reset edge
// - value 7 without mode aborts write
// - bits 11, 12 enable torque limits
// - bit4 edge waits for target reached
// - with bit5 set start immediately
// - bit 9 set is not supported
// - bit6 picks absolute or relative target
// - profile position halt stops axis
// - homing runs with bit4, halt clear
// - interpolation starts on rise, stops fall
// - interpolation halt gates bit4 instruction
// - halt-only mode uses bit 8 only
// - halt stops axis by halt option
// - set-point acknowledge clears when processed
module dcwd_top
  import dcwd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_od_wr,
  input wire logic i_od_rd,
  input wire logic [15:0] i_od_index,
  input wire logic [15:0] i_od_wdata,
  input wire logic [7:0] i_op_mode,
  input wire logic [HALT_OPTION_W-1:0] i_halt_option,
  input wire logic i_target_reached,
  input wire logic i_setpoint_processed,
  output logic o_od_done,
  output logic o_od_abort,
  output logic [31:0] o_od_abort_code,
  output logic [15:0] o_od_rdata,
  output dcwd_cmd_t o_drive_cmd,
  output logic o_fault_reset,
  output logic o_pos_start,
  output logic o_pos_relative,
  output logic o_setpoint_ack,
  output logic o_bit9_unsupported,
  output logic o_homing_run,
  output logic o_interp_run,
  output logic o_halt,
  output logic [HALT_OPTION_W-1:0] o_halt_method,
  output logic o_torque_limit_pos,
  output logic o_torque_limit_neg
);
  dcwd_cw_if cwb ();

  logic [15:0] cw;
  logic [15:0] prev_cw;
  logic update;
  logic pos_pending;

  dcwd_mode_t mode;
  dcwd_cmd_t dec_cmd;
  logic dec_fault_reset;
  logic dec_rise;
  logic dec_fall;
  logic dec_immediate;
  logic dec_relative;
  logic dec_halt;
  logic dec_bit9;
  logic dec_homing;

  // mode code to internal class
  always_comb begin
    case (i_op_mode)
      MODE_PROFILE_POSITION: mode = DCWD_MODE_PP;
      MODE_HOMING: mode = DCWD_MODE_HM;
      MODE_INTERPOLATED: mode = DCWD_MODE_IP;
      MODE_PROFILE_VELOCITY: mode = DCWD_MODE_HALT_ONLY;
      MODE_PROFILE_TORQUE: mode = DCWD_MODE_HALT_ONLY;
      default: mode = DCWD_MODE_UNSUPPORTED;
    endcase
  end

  assign cwb.cw = cw;
  assign cwb.prev_cw = prev_cw;
  assign cwb.update = update;
  assign cwb.mode = mode;

  dcwd_state_decoder u_state (
    .cwb(cwb),
    .o_cmd(dec_cmd),
    .o_fault_reset(dec_fault_reset)
  );

  dcwd_mode_decoder u_mode (
    .cwb(cwb),
    .o_start_rise(dec_rise),
    .o_start_fall(dec_fall),
    .o_immediate(dec_immediate),
    .o_relative(dec_relative),
    .o_halt(dec_halt),
    .o_bit9_unsupported(dec_bit9),
    .o_homing_run(dec_homing)
  );

  // access decode
  wire hit = (i_od_index == IDX_DRIVE_CONTROL_WORD);
  wire access = i_od_wr | i_od_rd;
  // servo on needs a supported mode
  wire no_mode_reject = i_od_wr & hit & (i_od_wdata == CW_SERVO_ON_VALUE) &
                        (mode == DCWD_MODE_UNSUPPORTED);
  wire accept_wr = i_od_wr & hit & ~no_mode_reject;
  wire next_abort = access & (~hit | no_mode_reject);
  wire [31:0] next_abort_code = ~access ? ABORT_NONE :
                                ~hit ? ABORT_NO_OBJECT :
                                no_mode_reject ? ABORT_NO_MODE : ABORT_NONE;

  // profile position start conditions
  wire is_pp = (mode == DCWD_MODE_PP);
  wire is_ip = (mode == DCWD_MODE_IP);
  // bit 9 set blocks new set-points
  wire pp_edge = is_pp & dec_rise & ~dec_bit9;
  wire start_now_imm = pp_edge & dec_immediate;
  wire start_now_wait = pp_edge & ~dec_immediate & i_target_reached;
  wire queue_wait = pp_edge & ~dec_immediate & ~i_target_reached;
  wire release_pending = pos_pending & i_target_reached & is_pp;
  wire next_pos_start = start_now_imm | start_now_wait | release_pending;
  wire next_pending = is_pp & (queue_wait | (pos_pending & ~release_pending));
  // ack clears once processed, a new start wins
  wire next_ack = next_pos_start | next_pending |
                  (o_setpoint_ack & is_pp & ~i_setpoint_processed);

  // halt clear lets bit 4 act
  wire ip_on = is_ip & dec_rise & ~dec_halt;
  wire ip_off = dec_fall | ~is_ip;
  wire next_interp = ip_on | (o_interp_run & ~ip_off);

  // control word register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cw <= CW_RESET;
      prev_cw <= CW_RESET;
      update <= 1'b0;
    end else begin
      update <= accept_wr;
      if (accept_wr) begin
        prev_cw <= cw;
        cw <= i_od_wdata;
      end
    end
  end

  // access answer
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_od_done <= 1'b0;
      o_od_abort <= 1'b0;
      o_od_abort_code <= ABORT_NONE;
      o_od_rdata <= CW_RESET;
    end else begin
      o_od_done <= access;
      o_od_abort <= next_abort;
      o_od_abort_code <= next_abort_code;
      o_od_rdata <= (i_od_rd & hit) ? cw : CW_RESET;
    end
  end

  // drive-state command outputs
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_drive_cmd <= DCWD_CMD_NONE;
      o_fault_reset <= 1'b0;
    end else begin
      o_drive_cmd <= dec_cmd;
      o_fault_reset <= dec_fault_reset;
    end
  end

  // positioning
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pos_start <= 1'b0;
      pos_pending <= 1'b0;
      o_setpoint_ack <= 1'b0;
      o_pos_relative <= 1'b0;
      o_bit9_unsupported <= 1'b0;
    end else begin
      o_pos_start <= next_pos_start;
      pos_pending <= next_pending;
      o_setpoint_ack <= next_ack;
      o_pos_relative <= dec_relative;
      o_bit9_unsupported <= dec_bit9;
    end
  end

  // homing, interpolation, halt and torque limits
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_homing_run <= 1'b0;
      o_interp_run <= 1'b0;
      o_halt <= 1'b0;
      o_halt_method <= HALT_OPTION_RESET;
      o_torque_limit_pos <= 1'b0;
      o_torque_limit_neg <= 1'b0;
    end else begin
      o_homing_run <= dec_homing;
      o_interp_run <= next_interp;
      o_halt <= dec_halt;
      o_halt_method <= i_halt_option;
      o_torque_limit_pos <= cw[BIT_TORQUE_LIMIT_POS];
      o_torque_limit_neg <= cw[BIT_TORQUE_LIMIT_NEG];
    end
  end
endmodule : dcwd_top

// [rtl/dcwd_pkg.sv]
// constants and types shared by the drive control word decoder
package dcwd_pkg;
  // object dictionary indices
  localparam logic [15:0] IDX_DRIVE_CONTROL_WORD = 16'h6040;
  localparam logic [15:0] CW_RESET = 16'h0000;
  // control word bit positions
  localparam int BIT_SWITCH_ON = 0;
  localparam int BIT_ENABLE_VOLTAGE = 1;
  localparam int BIT_QUICK_STOP = 2;
  localparam int BIT_ENABLE_OPERATION = 3;
  localparam int BIT_MODE_START = 4;
  localparam int BIT_MODE_IMMEDIATE = 5;
  localparam int BIT_MODE_RELATIVE = 6;
  localparam int BIT_FAULT_RESET = 7;
  localparam int BIT_HALT = 8;
  localparam int BIT_MODE_SPECIFIC9 = 9;
  localparam int BIT_TORQUE_LIMIT_POS = 11;
  localparam int BIT_TORQUE_LIMIT_NEG = 12;
  // bits that carry a meaning in some mode; all others are ignored
  localparam logic [15:0] CW_USED_MASK = 16'h1BFF;
  // whole-word value that asks for servo on
  localparam logic [15:0] CW_SERVO_ON_VALUE = 16'h0007;
  // abort codes
  localparam logic [31:0] ABORT_NO_MODE = 32'h0800_0022;
  localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
  localparam logic [31:0] ABORT_NONE = 32'h0000_0000;
  // operating mode codes
  localparam logic [7:0] MODE_NONE = 8'h00;
  localparam logic [7:0] MODE_PROFILE_POSITION = 8'h01;
  localparam logic [7:0] MODE_PROFILE_VELOCITY = 8'h03;
  localparam logic [7:0] MODE_PROFILE_TORQUE = 8'h04;
  localparam logic [7:0] MODE_HOMING = 8'h06;
  localparam logic [7:0] MODE_INTERPOLATED = 8'h07;
  localparam int HALT_OPTION_W = 3;
  localparam logic [HALT_OPTION_W-1:0] HALT_OPTION_RESET = 3'h0;

  typedef enum logic [2:0] {
    DCWD_CMD_NONE = 3'b000,
    DCWD_CMD_SHUTDOWN = 3'b001,
    DCWD_CMD_SWITCH_ON = 3'b010,
    DCWD_CMD_ENABLE_OP = 3'b011,
    DCWD_CMD_DISABLE_VOLT = 3'b100,
    DCWD_CMD_QUICK_STOP = 3'b101
  } dcwd_cmd_t;

  typedef enum logic [2:0] {
    DCWD_MODE_UNSUPPORTED = 3'b000,
    DCWD_MODE_PP = 3'b001,
    DCWD_MODE_HM = 3'b010,
    DCWD_MODE_IP = 3'b011,
    DCWD_MODE_HALT_ONLY = 3'b100
  } dcwd_mode_t;
endpackage : dcwd_pkg

// [rtl/dcwd_cw_if.sv]
// carries the held control word and its update event to the decoders
interface dcwd_cw_if;
  import dcwd_pkg::*;
  logic [15:0] cw;
  logic [15:0] prev_cw;
  logic update;
  dcwd_mode_t mode;
  modport owner (output cw, output prev_cw, output update, output mode);
  modport dec (input cw, input prev_cw, input update, input mode);
endinterface : dcwd_cw_if

// [rtl/dcwd_state_decoder.sv]
// decodes the drive-state command bits of the control word
module dcwd_state_decoder
  import dcwd_pkg::*;
(
  dcwd_cw_if.dec cwb,
  output dcwd_cmd_t o_cmd,
  output logic o_fault_reset
);
  wire fr_level = cwb.cw[BIT_FAULT_RESET];
  wire ev = cwb.cw[BIT_ENABLE_VOLTAGE];
  wire qs = cwb.cw[BIT_QUICK_STOP];
  wire so = cwb.cw[BIT_SWITCH_ON];
  wire eo = cwb.cw[BIT_ENABLE_OPERATION];

  always_comb begin
    o_cmd = DCWD_CMD_NONE;
    if (!fr_level) begin
      if (!ev) begin
        o_cmd = DCWD_CMD_DISABLE_VOLT;
      end else if (!qs) begin
        o_cmd = DCWD_CMD_QUICK_STOP;
      end else if (!so) begin
        o_cmd = DCWD_CMD_SHUTDOWN;
      end else if (!eo) begin
        o_cmd = DCWD_CMD_SWITCH_ON;
      end else begin
        o_cmd = DCWD_CMD_ENABLE_OP;
      end
    end
  end

  assign o_fault_reset = cwb.update & fr_level & ~cwb.prev_cw[BIT_FAULT_RESET];
endmodule : dcwd_state_decoder

// [rtl/dcwd_mode_decoder.sv]
// interprets the mode-specific bits 4-6, 8 and 9
module dcwd_mode_decoder
  import dcwd_pkg::*;
(
  dcwd_cw_if.dec cwb,
  output logic o_start_rise,
  output logic o_start_fall,
  output logic o_immediate,
  output logic o_relative,
  output logic o_halt,
  output logic o_bit9_unsupported,
  output logic o_homing_run
);
  wire b4 = cwb.cw[BIT_MODE_START];
  wire b4_prev = cwb.prev_cw[BIT_MODE_START];
  wire is_pp = (cwb.mode == DCWD_MODE_PP);
  wire is_hm = (cwb.mode == DCWD_MODE_HM);
  wire is_ip = (cwb.mode == DCWD_MODE_IP);
  wire supported = (cwb.mode != DCWD_MODE_UNSUPPORTED);

  assign o_halt = supported & cwb.cw[BIT_HALT];
  assign o_bit9_unsupported = cwb.cw[BIT_MODE_SPECIFIC9];
  assign o_start_rise = cwb.update & b4 & ~b4_prev & (is_pp | is_ip);
  assign o_start_fall = cwb.update & ~b4 & b4_prev & is_ip;
  assign o_immediate = is_pp & cwb.cw[BIT_MODE_IMMEDIATE];
  assign o_relative = is_pp & cwb.cw[BIT_MODE_RELATIVE];
  // homing runs while bit 4 set and no halt
  assign o_homing_run = is_hm & b4 & ~cwb.cw[BIT_HALT];
endmodule : dcwd_mode_decoder

// [testbench/dcwd_top_props.sv]
// port assertions for the control word decoder
module dcwd_props
  import dcwd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_od_wr,
  input wire logic i_od_rd,
  input wire logic [15:0] i_od_index,
  input wire logic [15:0] i_od_wdata,
  input wire logic [7:0] i_op_mode,
  input wire logic o_od_done,
  input wire logic o_od_abort,
  input wire logic [31:0] o_od_abort_code,
  input wire dcwd_cmd_t o_drive_cmd,
  input wire logic o_fault_reset,
  input wire logic o_torque_limit_pos,
  input wire logic o_torque_limit_neg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire logic cw_hit = i_od_index == IDX_DRIVE_CONTROL_WORD;
  wire logic mode_ok = i_op_mode inside {8'h01, 8'h03, 8'h04, 8'h06, 8'h07};
  wire logic servo_on = i_od_wr && cw_hit && i_od_wdata == CW_SERVO_ON_VALUE;
  wire logic wr_ok = i_od_wr && cw_hit && !(servo_on && !mode_ok);
  // accepted write followed by a quiet cycle
  sequence s_settle;
    wr_ok ##1 !wr_ok;
  endsequence
  chk_done_follow: assert property ((i_od_wr || i_od_rd) |=> o_od_done)
    else $error("done missing");
  chk_done_cause: assert property (o_od_done |-> $past(i_od_wr || i_od_rd))
    else $error("done without request");
  chk_write_ok: assert property (wr_ok |=> !o_od_abort)
    else $error("valid write refused");
  chk_mode_abort: assert property ((servo_on && !mode_ok) |=>
    o_od_abort && o_od_abort_code == ABORT_NO_MODE) else $error("no mode abort");
  chk_shutdown_dec: assert property ((wr_ok && i_od_wdata[7] == 1'b0 &&
    i_od_wdata[2:0] == 3'b110) ##1 !wr_ok |=> o_drive_cmd == DCWD_CMD_SHUTDOWN)
    else $error("shutdown decode");
  chk_enable_dec: assert property ((wr_ok && i_od_wdata[7:0] == 8'h0F) ##1 !wr_ok
    |=> o_drive_cmd == DCWD_CMD_ENABLE_OP) else $error("enable decode");
  chk_torque_pos: assert property (s_settle |=>
    o_torque_limit_pos == $past(i_od_wdata[11], 2)) else $error("positive limit");
  chk_torque_neg: assert property (s_settle |=>
    o_torque_limit_neg == $past(i_od_wdata[12], 2)) else $error("negative limit");
  chk_fault_once: assert property (o_fault_reset |=> !o_fault_reset)
    else $error("fault reset too long");
endmodule : dcwd_props

// [testbench/dcwd_master.sv]
// network master model issuing object reads and writes
module dcwd_master (
  input wire logic i_clk,
  input wire logic i_done,
  input wire logic i_abort,
  input wire logic [31:0] i_code,
  input wire logic [15:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_index,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic done, abort;
  logic [31:0] code;
  logic [15:0] rdata;
  // torque limit parameters are taken as set beforehand
  initial begin
    {o_wr, o_rd, o_index, o_wdata} = '0;
  end
  // request held over its taking edge, answer taken one cycle on
  task automatic access(input logic wr, input logic rd, input logic [15:0] idx,
      input logic [15:0] data);
    @(negedge i_clk);
    {o_wr, o_rd, o_index, o_wdata} = {wr, rd, idx, data};
    @(negedge i_clk);
    // strobes drop to 0, index and data lines show the inverse of the last value
    {o_wr, o_rd, o_index, o_wdata} = {1'b0, 1'b0, ~idx, ~data};
    {done, abort, code, rdata} = {i_done, i_abort, i_code, i_rdata};
  endtask : access
endmodule : dcwd_master

// [testbench/dcwd_top_tb.sv]
// self-checking bench for the control word decoder
module dcwd_top_tb;
  import dcwd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_nrst, i_od_wr, i_od_rd, i_target_reached, i_setpoint_processed;
  logic [15:0] i_od_index, i_od_wdata, o_od_rdata;
  logic [7:0] i_op_mode;
  logic [2:0] i_halt_option, o_halt_method;
  logic [31:0] o_od_abort_code;
  dcwd_cmd_t o_drive_cmd;
  logic o_od_done, o_od_abort, o_fault_reset, o_pos_start, o_pos_relative, o_setpoint_ack;
  logic o_bit9_unsupported, o_homing_run, o_interp_run, o_halt;
  logic o_torque_limit_pos, o_torque_limit_neg, seen;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  dcwd_top dut_u (.*);
  dcwd_master mst_u (.i_clk(i_clk), .i_done(o_od_done), .i_abort(o_od_abort),
    .i_code(o_od_abort_code), .i_rdata(o_od_rdata), .o_wr(i_od_wr), .o_rd(i_od_rd),
    .o_index(i_od_index), .o_wdata(i_od_wdata));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // write, then wait until decoded outputs show the word
  task automatic wr(input logic [15:0] d);
    mst_u.access(1'b1, 1'b0, IDX_DRIVE_CONTROL_WORD, d);
    @(negedge i_clk);
  endtask : wr
  task automatic rd(input logic [15:0] idx);
    mst_u.access(1'b0, 1'b1, idx, 16'h0000);
  endtask : rd
  task automatic t_regs;
    rd(IDX_DRIVE_CONTROL_WORD);
    chk("reset word", CW_RESET, mst_u.rdata);
    chk("done", 1'b1, mst_u.done);
    rd(16'h6041);
    chk("unmapped", ABORT_NO_OBJECT, mst_u.code);
    chk("unmapped abort", 1'b1, mst_u.abort);
    // bit 5 set would start at once, so only bit 9 can hold the start back
    wr(16'hFFFF);
    chk("bit9 start", 1'b0, o_pos_start);
    rd(IDX_DRIVE_CONTROL_WORD);
    chk("word", 16'hFFFF, mst_u.rdata);
    chk("limits", 2'b11, {o_torque_limit_pos, o_torque_limit_neg});
    chk("bit9", 1'b1, o_bit9_unsupported);
    wr(16'hEC06);
    chk("pos limit", 2'b10, {o_torque_limit_pos, o_torque_limit_neg});
    chk("unused bits", DCWD_CMD_SHUTDOWN, o_drive_cmd);
  endtask : t_regs
  task automatic t_cmds;
    logic [15:0] w[7] = '{16'h0006, 16'h000E, 16'h0007, 16'h000F, 16'h0009, 16'h000B,
      16'h0086};
    dcwd_cmd_t c[7] = '{DCWD_CMD_SHUTDOWN, DCWD_CMD_SHUTDOWN, DCWD_CMD_SWITCH_ON,
      DCWD_CMD_ENABLE_OP, DCWD_CMD_DISABLE_VOLT, DCWD_CMD_QUICK_STOP, DCWD_CMD_NONE};
    foreach (w[k]) begin
      wr(w[k]);
      chk("command", c[k], o_drive_cmd);
      chk("fault reset", w[k][7], o_fault_reset);
    end
  endtask : t_cmds
  task automatic t_nomode;
    i_op_mode = 8'h00;
    mst_u.access(1'b1, 1'b0, IDX_DRIVE_CONTROL_WORD, CW_SERVO_ON_VALUE);
    chk("no mode", ABORT_NO_MODE, mst_u.code);
    chk("no mode abort", 1'b1, mst_u.abort);
    rd(IDX_DRIVE_CONTROL_WORD);
    chk("kept", 16'h0086, mst_u.rdata);
  endtask : t_nomode
  task automatic t_pp;
    i_op_mode = 8'h01;
    wr(16'h0000);
    wr(16'h0050);
    chk("held start", 1'b0, o_pos_start);
    chk("relative", 1'b1, o_pos_relative);
    chk("ack", 1'b1, o_setpoint_ack);
    i_target_reached = 1'b1;
    seen = 1'b0;
    repeat (3) begin
      @(negedge i_clk);
      seen = seen | o_pos_start;
    end
    chk("late start", 1'b1, seen);
    i_setpoint_processed = 1'b1;
    repeat (2) @(negedge i_clk);
    chk("ack clear", 1'b0, o_setpoint_ack);
    {i_target_reached, i_setpoint_processed} = 2'b00;
    wr(16'h0020);
    wr(16'h0030);
    chk("now start", 1'b1, o_pos_start);
    wr(16'h0100);
    chk("halt", 1'b1, o_halt);
    chk("method", 3'h5, o_halt_method);
  endtask : t_pp
  task automatic t_modes;
    i_op_mode = 8'h06;
    wr(16'h0010);
    chk("homing", 1'b1, o_homing_run);
    wr(16'h0110);
    chk("homing halt", 1'b0, o_homing_run);
    i_op_mode = 8'h07;
    wr(16'h0000);
    wr(16'h0010);
    chk("interp on", 1'b1, o_interp_run);
    wr(16'h0000);
    chk("interp off", 1'b0, o_interp_run);
    wr(16'h0110);
    chk("interp halt", 1'b0, o_interp_run);
    i_op_mode = 8'h03;
    wr(16'h0000);
    chk("halt only clear", 1'b0, o_halt);
    wr(16'h0010);
    chk("reserved bit4", 1'b0, o_homing_run | o_interp_run | o_pos_start);
    wr(16'h0100);
    chk("halt only", 1'b1, o_halt);
  endtask : t_modes
  // reset in mid-run brings the word back to its default
  task automatic t_rst;
    i_nrst = 1'b0;
    repeat (2) @(negedge i_clk);
    chk("reset halt", 1'b0, o_halt);
    i_nrst = 1'b1;
    rd(IDX_DRIVE_CONTROL_WORD);
    chk("reset again", CW_RESET, mst_u.rdata);
  endtask : t_rst
  task automatic finish_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    {i_nrst, i_target_reached, i_setpoint_processed} = 3'b000;
    i_op_mode = 8'h01;
    i_halt_option = 3'h5;
    repeat (5) @(negedge i_clk);
    i_nrst = 1'b1;
    t_regs();
    t_cmds();
    t_nomode();
    t_pp();
    t_modes();
    t_rst();
    finish_test();
  end
endmodule : dcwd_top_tb
bind dcwd_top dcwd_props chk_u (.*);
